/* File: src/modulo_timer.sv */
// Eight-bit modulo timer with an AXI4-Lite register slave.
// Assumes one 25 MHz clock, a synchronous active-low reset and an asynchronous pin.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "modulo_timer_params.svh"

module modulo_timer #(
	parameter logic [7:0] FIXED_FREQUENCY_CLOCK_DIV = `FIXED_FREQUENCY_CLOCK_DIV
) (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel.
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	// Write data channel.
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// Write response channel.
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// Read address channel.
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	// Read data channel.
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Timer pin and interrupt.
	input  wire logic        external_timer_clock_pin,
	output logic             overflow_irq
);

	// ----------------------------------------
	// Register state.
	// ----------------------------------------
	logic                     overflow_flag_reg;
	logic                     overflow_irq_enable_reg;
	logic                     counter_stop_bit_reg;
	modulo_timer_pkg::clk_cfg_s clk_cfg_reg;
	logic [7:0]               count_reg;
	logic [7:0]               modulo_value_reg;
	logic                     clear_armed_reg;
	logic                     irq_reg;

	// ----------------------------------------
	// Bus handshake state.
	// ----------------------------------------
	logic                     awready_reg;
	logic                     wready_reg;
	logic                     bvalid_reg;
	logic [1:0]               bresp_reg;
	logic                     arready_reg;
	logic                     rvalid_reg;
	logic [31:0]              rdata_reg;
	logic [1:0]               rresp_reg;
	logic [7:0]               wr_addr_reg;
	logic [7:0]               wr_data_reg;
	logic                     wr_lane_reg;
	logic                     aw_full_reg;
	logic                     w_full_reg;
	logic                     rd_status_reg;

	// ----------------------------------------
	// Clock sources and prescaler.
	// ----------------------------------------
	logic                     pin_s1_reg;
	logic                     pin_s2_reg;
	logic                     pin_s3_reg;
	logic [7:0]               fixed_frequency_clock_cnt_reg;
	logic                     fixed_frequency_clock_en_reg;
	logic [7:0]               prescaler_reg;

	// ----------------------------------------
	// Combinational terms.
	// ----------------------------------------
	logic                     wr_do;
	logic                     wr_status;
	logic                     wr_clock;
	logic                     wr_modulo;
	logic                     wr_mapped;
	logic                     rd_take;
	logic                     rd_mapped;
	logic                     ctr_reset_w;
	logic                     src_en;
	logic                     pre_en;
	logic [3:0]               ps_eff;
	logic [7:0]               tap_mask;
	logic                     tick;
	logic [7:0]               limit;
	logic                     wrap;
	logic                     pin_rise;
	logic                     pin_fall;
	logic [31:0]              rd_word;

	// ----------------------------------------
	// Outputs straight from flip-flops.
	// ----------------------------------------
	assign awready      = awready_reg;
	assign wready       = wready_reg;
	assign bvalid       = bvalid_reg;
	assign bresp        = bresp_reg;
	assign arready      = arready_reg;
	assign rvalid       = rvalid_reg;
	assign rdata        = rdata_reg;
	assign rresp        = rresp_reg;
	assign overflow_irq = irq_reg;

	// ----------------------------------------
	// Write decode.
	// ----------------------------------------
	assign wr_do     = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_mapped = (wr_addr_reg == `OFS_STATUS_CONTROL) || (wr_addr_reg == `OFS_CLOCK_CONFIG)
		|| (wr_addr_reg == `OFS_COUNT_VALUE) || (wr_addr_reg == `OFS_MODULO_LIMIT);
	assign wr_status = wr_do && wr_lane_reg && (wr_addr_reg == `OFS_STATUS_CONTROL);
	assign wr_clock  = wr_do && wr_lane_reg && (wr_addr_reg == `OFS_CLOCK_CONFIG);
	assign wr_modulo = wr_do && wr_lane_reg && (wr_addr_reg == `OFS_MODULO_LIMIT);
	assign ctr_reset_w = (wr_status && wr_data_reg[`BIT_CTR_RESET]) || wr_modulo;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			aw_full_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (awvalid && awready_reg) begin
			awready_reg <= 1'b0;
			aw_full_reg <= 1'b1;
			wr_addr_reg <= {awaddr[7:2], 2'h0};
		end else if (bvalid_reg && bready) begin
			awready_reg <= 1'b1;
			aw_full_reg <= 1'b0;
		end else if (!aw_full_reg) begin
			awready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_reg  <= 1'b0;
			w_full_reg  <= 1'b0;
			wr_data_reg <= 8'h00;
			wr_lane_reg <= 1'b0;
		end else if (wvalid && wready_reg) begin
			wready_reg  <= 1'b0;
			w_full_reg  <= 1'b1;
			wr_data_reg <= wdata[7:0];
			wr_lane_reg <= wstrb[0];
		end else if (bvalid_reg && bready) begin
			wready_reg <= 1'b1;
			w_full_reg <= 1'b0;
		end else if (!w_full_reg) begin
			wready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= modulo_timer_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? modulo_timer_pkg::RESP_OKAY : modulo_timer_pkg::RESP_DECERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read path.
	// ----------------------------------------
	assign rd_take   = arvalid && arready_reg;
	assign rd_mapped = (araddr[7:2] <= 6'h03) && (araddr[1:0] == 2'h0) ? 1'b1 : (araddr[7:4] == 4'h0);

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case ({araddr[7:2], 2'h0})
			`OFS_STATUS_CONTROL: rd_word[7:0] = {overflow_flag_reg, overflow_irq_enable_reg, 1'b0,
				counter_stop_bit_reg, 4'h0};
			`OFS_CLOCK_CONFIG:   rd_word[7:0] = {2'h0, clk_cfg_reg};
			`OFS_COUNT_VALUE:    rd_word[7:0] = count_reg;
			`OFS_MODULO_LIMIT:   rd_word[7:0] = modulo_value_reg;
			default:             rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg   <= 1'b0;
			rvalid_reg    <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			rresp_reg     <= modulo_timer_pkg::RESP_OKAY;
			rd_status_reg <= 1'b0;
		end else if (rd_take) begin
			arready_reg   <= 1'b0;
			rvalid_reg    <= 1'b1;
			rdata_reg     <= rd_word;
			rresp_reg     <= rd_mapped ? modulo_timer_pkg::RESP_OKAY : modulo_timer_pkg::RESP_DECERR;
			rd_status_reg <= ({araddr[7:2], 2'h0} == `OFS_STATUS_CONTROL);
		end else if (rvalid_reg && rready) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end else if (!rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Control registers.
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_irq_enable_reg <= 1'b0;
			counter_stop_bit_reg    <= `RST_STOP;
		end else if (wr_status) begin
			overflow_irq_enable_reg <= wr_data_reg[`BIT_IRQ_EN];
			counter_stop_bit_reg    <= wr_data_reg[`BIT_STOP];
		end
	end

	// Configuration changes leave the count and the prescaler untouched.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_cfg_reg.clock_source_select <= modulo_timer_pkg::clk_src_e'(`RST_CLK_SRC);
			clk_cfg_reg.prescale_select     <= `RST_PRESCALE;
		end else if (wr_clock) begin
			clk_cfg_reg <= modulo_timer_pkg::clk_cfg_s'(wr_data_reg[5:0]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modulo_value_reg <= `RST_MODULO;
		end else if (wr_modulo) begin
			modulo_value_reg <= wr_data_reg;
		end
	end

	// ----------------------------------------
	// Clock sources.
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
		end else begin
			pin_s1_reg <= external_timer_clock_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign pin_rise = pin_s2_reg && !pin_s3_reg;
	assign pin_fall = !pin_s2_reg && pin_s3_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fixed_frequency_clock_cnt_reg <= 8'h00;
			fixed_frequency_clock_en_reg  <= 1'b0;
		end else if (fixed_frequency_clock_cnt_reg == FIXED_FREQUENCY_CLOCK_DIV - 8'h01) begin
			fixed_frequency_clock_cnt_reg <= 8'h00;
			fixed_frequency_clock_en_reg  <= 1'b1;
		end else begin
			fixed_frequency_clock_cnt_reg <= fixed_frequency_clock_cnt_reg + 8'h01;
			fixed_frequency_clock_en_reg  <= 1'b0;
		end
	end

	always_comb begin
		unique case (clk_cfg_reg.clock_source_select)
			modulo_timer_pkg::SRC_BUS:   src_en = 1'b1;
			modulo_timer_pkg::SRC_FIXED: src_en = fixed_frequency_clock_en_reg;
			modulo_timer_pkg::SRC_FALL:  src_en = pin_fall;
			modulo_timer_pkg::SRC_RISE:  src_en = pin_rise;
		endcase
	end

	// ----------------------------------------
	// Prescaler and counter.
	// ----------------------------------------
	assign pre_en   = src_en && !counter_stop_bit_reg;
	assign ps_eff   = (clk_cfg_reg.prescale_select > `PRESCALE_MAX) ? `PRESCALE_MAX
		: clk_cfg_reg.prescale_select;
	assign tap_mask = ~(8'hFF << ps_eff);
	assign tick     = pre_en && ((prescaler_reg & tap_mask) == tap_mask);
	assign limit    = (modulo_value_reg == 8'h00) ? 8'hFF : modulo_value_reg;
	assign wrap     = tick && (count_reg == limit) && !ctr_reset_w;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescaler_reg <= 8'h00;
		end else if (ctr_reset_w) begin
			prescaler_reg <= 8'h00;
		end else if (pre_en) begin
			prescaler_reg <= prescaler_reg + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= 8'h00;
		end else if (ctr_reset_w) begin
			count_reg <= 8'h00;
		end else if (wrap) begin
			count_reg <= 8'h00;
		end else if (tick) begin
			count_reg <= count_reg + 8'h01;
		end
	end

	// ----------------------------------------
	// Overflow flag and clear sequence.
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_flag_reg <= 1'b0;
		end else if (wrap) begin
			overflow_flag_reg <= 1'b1;
		end else if (ctr_reset_w) begin
			overflow_flag_reg <= 1'b0;
		end else if (wr_status && clear_armed_reg && !wr_data_reg[`BIT_OVF_FLAG]) begin
			overflow_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clear_armed_reg <= 1'b0;
		end else if (wrap || wr_status || ctr_reset_w) begin
			clear_armed_reg <= 1'b0;
		end else if (rd_take && ({araddr[7:2], 2'h0} == `OFS_STATUS_CONTROL) && overflow_flag_reg) begin
			clear_armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= overflow_flag_reg && overflow_irq_enable_reg;
		end
	end

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_wrap_sets_flag:
	assert property (tick && !ctr_reset_w && count_reg == limit |=> overflow_flag_reg && count_reg == 8'h00)
		else $error("Overflow did not set the flag.");

	a_clear_needs_read:
	assert property ($fell(overflow_flag_reg) |-> $past(clear_armed_reg) || $past(ctr_reset_w))
		else $error("Flag cleared without a prior status read.");

	a_reset_bit_clears:
	assert property (wr_status && wr_data_reg[`BIT_CTR_RESET] |=> count_reg == 8'h00 && !overflow_flag_reg)
		else $error("Counter reset did not clear count and flag.");

	a_irq_follows_flag:
	assert property (overflow_flag_reg && overflow_irq_enable_reg |=> overflow_irq)
		else $error("Interrupt not raised.");

	a_stop_holds_count:
	assert property (counter_stop_bit_reg && !ctr_reset_w |=> $stable(count_reg))
		else $error("Count moved while stopped.");

	a_reset_defaults:
	assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> counter_stop_bit_reg
		&& !overflow_irq_enable_reg && !overflow_flag_reg && clk_cfg_reg == 6'h00 && count_reg == 8'h00)
		else $error("Wrong values after reset.");

	a_unused_read_zero:
	assert property (rvalid && rd_status_reg |-> rdata[5] == 1'b0 && rdata[3:0] == 4'h0)
		else $error("Unused status bits read nonzero.");

	a_modulo_write_clears:
	assert property (wr_modulo |=> count_reg == 8'h00 && !overflow_flag_reg ##1 modulo_value_reg == $past(wr_data_reg, 2))
		else $error("Modulo write did not reset the count.");

	a_overflow_rearms:
	assert property (wrap |=> !clear_armed_reg && overflow_flag_reg)
		else $error("Overflow did not restart the clear sequence.");

	a_tick_max_division:
	assert property (tick && clk_cfg_reg.prescale_select >= `PRESCALE_MAX |-> prescaler_reg == 8'hFF)
		else $error("Division above 256 codes is wrong.");

endmodule : modulo_timer
`default_nettype wire

/* File: src/modulo_timer_params.svh */
// Offsets, field positions, reset values and timing counts of the modulo timer.
// Assumes an AXI4-Lite slave with 32-bit data and one register per aligned word.
//
// Summary of operation
// - Overflow flag, status bit 7, sets when the count wraps from modulo to zero.
// - Overflow flag clears by a status read while set, then writing zero.
// - Writing one to counter reset, or any modulo write, also clears the flag.
// - Interrupt request is high while interrupt enable bit 6 and the flag are set.
// - Writing one to write-only bit 5 zeroes count and flag; reads return zero.
// - While stop bit 4 is set the count holds; clearing it resumes counting.
// - Reset sets the stop bit so the timer idles until software clears it.
// - Status bits 3:0 and clock configuration bits 7:6 always read zero.
// - Source field 5:4 picks bus clock, fixed clock, pin falling or rising edge.
// - Changing the source while running keeps the count and uses the new source.
// - Reset clears the source field, selecting the bus clock.
// - Prescale field 3:0 divides by two to the field value, one to 256.
// - Prescale codes above eight divide by 256.
// - Changing the prescale while running keeps the count at the new rate.
// - Reset clears the prescale field, selecting division by one.
// - The count is readable as an 8-bit register; writes have no effect.
// - An 8-bit read-write modulo register holds the overflow limit.
// - While running the count increments at the prescaled rate, wraps after modulo.
// - A modulo of zero makes the counter run freely over all 8 bits.
// - An overflow between status read and clearing write restarts the clear sequence.
// - Any modulo write also resets the count to zero.
`ifndef MODULO_TIMER_PARAMS_SVH
`define MODULO_TIMER_PARAMS_SVH

`define OFS_STATUS_CONTROL 8'h00
`define OFS_CLOCK_CONFIG   8'h04
`define OFS_COUNT_VALUE    8'h08
`define OFS_MODULO_LIMIT   8'h0C

`define BIT_OVF_FLAG  7
`define BIT_IRQ_EN    6
`define BIT_CTR_RESET 5
`define BIT_STOP      4

`define RST_STOP      1'b1
`define RST_MODULO    8'h00
`define RST_CLK_SRC   2'h0
`define RST_PRESCALE  4'h0
`define PRESCALE_MAX  4'h8

`define FIXED_FREQUENCY_CLOCK_DIV      8'h19

`endif

/* File: src/modulo_timer_pkg.sv */
// Types shared by the modulo timer.
// Assumes the constants header is included where the offsets are needed.
package modulo_timer_pkg;

	typedef enum logic [1:0] {
		SRC_BUS   = 2'h0,
		SRC_FIXED = 2'h1,
		SRC_FALL  = 2'h2,
		SRC_RISE  = 2'h3
	} clk_src_e;

	typedef struct packed {
		clk_src_e   clock_source_select;
		logic [3:0] prescale_select;
	} clk_cfg_s;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'h0,
		RESP_DECERR = 2'h3
	} axi_resp_e;

endpackage : modulo_timer_pkg

/* File: tb/modulo_timer_bench.sv */
// Self-checking bench for the modulo timer, driving its AXI4-Lite slave and timer pin.
// Assumes the design package and constants header are compiled and included first.
`timescale 1ns/1ns
`default_nettype none
`include "modulo_timer_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end

module modulo_timer_bench;
	// ----------------------------------------
	// Signals and constants
	// ----------------------------------------
	localparam logic [7:0] XDIV = 8'h04;
	localparam logic [7:0] ST   = `OFS_STATUS_CONTROL;
	localparam logic [7:0] CK   = `OFS_CLOCK_CONFIG;
	localparam logic [7:0] CN   = `OFS_COUNT_VALUE;
	localparam logic [7:0] MD   = `OFS_MODULO_LIMIT;
	localparam logic [7:0] F    = 8'h01 << `BIT_OVF_FLAG;
	localparam logic [7:0] IE   = 8'h01 << `BIT_IRQ_EN;
	localparam logic [7:0] TR   = 8'h01 << `BIT_CTR_RESET;
	localparam logic [7:0] SP   = 8'h01 << `BIT_STOP;
	localparam logic [1:0] DEC  = modulo_timer_pkg::RESP_DECERR;
	logic        aclk;
	logic        aresetn;
	logic        awvalid;
	logic        awready;
	logic [7:0]  awaddr;
	logic [2:0]  awprot;
	logic        wvalid;
	logic        wready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        bvalid;
	logic        bready;
	logic [1:0]  bresp;
	logic        arvalid;
	logic        arready;
	logic [7:0]  araddr;
	logic [2:0]  arprot;
	logic        rvalid;
	logic        rready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        pin;
	logic        overflow_irq;
	logic [31:0] rs;
	logic [7:0]  v;
	logic [7:0]  m;
	int          bad_count;
	int          n_checks;
	int          cyc = 0;
	int          k;

	modulo_timer #(.FIXED_FREQUENCY_CLOCK_DIV(XDIV)) modulo_timer_inst (
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.awvalid                  (awvalid),
		.awready                  (awready),
		.awaddr                   (awaddr),
		.awprot                   (awprot),
		.wvalid                   (wvalid),
		.wready                   (wready),
		.wdata                    (wdata),
		.wstrb                    (wstrb),
		.bvalid                   (bvalid),
		.bready                   (bready),
		.bresp                    (bresp),
		.arvalid                  (arvalid),
		.arready                  (arready),
		.araddr                   (araddr),
		.arprot                   (arprot),
		.rvalid                   (rvalid),
		.rready                   (rready),
		.rdata                    (rdata),
		.rresp                    (rresp),
		.external_timer_clock_pin (pin),
		.overflow_irq             (overflow_irq)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int exp_ticks(input int d, input logic [1:0] src, input logic [3:0] ps);
		int dv;
		dv = (src == 2'h0) ? 1 : (src == 2'h1) ? int'(XDIV) : 8;
		return (d + 3) / (dv << ((ps > 4'h8) ? 8 : int'(ps)));
	endfunction : exp_ticks

	function automatic logic in_tol(input logic [7:0] c, input int e);
		return (int'(c) + 2 >= e) && (int'(c) <= e + 2);
	endfunction : in_tol

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		rs = lfsr(rs);
		awaddr  <= a;
		awprot  <= rs[2:0];
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		`CHK(bvalid, 1'b1);
		`CHK(bresp, er);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		rs = lfsr(rs);
		araddr  <= a;
		arprot  <= rs[2:0];
		arvalid <= 1'b1;
		rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		`CHK(rvalid, 1'b1);
		`CHK(rresp, er);
		`CHK(rdata[31:8], 24'h0);
		d = rdata[7:0];
		rready <= 1'b0;
	endtask : rd

	// Runs the counter for d cycles from zero, then checks the count and that it holds.
	task automatic measure(input logic [1:0] src, input logic [3:0] ps, input int d);
		logic [7:0] c;
		logic [7:0] x;
		modulo_timer_pkg::clk_cfg_s cfg;
		cfg = '{clock_source_select: modulo_timer_pkg::clk_src_e'(src), prescale_select: ps};
		wr(CK, {2'b00, cfg});
		wr(ST, SP | TR);
		wr(ST, 8'h00);
		repeat (d) @(posedge aclk);
		wr(ST, SP);
		rd(CN, c);
		`CHK(in_tol(c, exp_ticks(d, src, ps)), 1'b1);
		rd(CN, x);
		`CHK(x, c);
		wr(CK, {2'b00, ~src, ps + 4'h1});
		rd(CN, x);
		`CHK(x, c);
		wr(CN, rs[7:0]);
		rd(CN, x);
		`CHK(x, c);
	endtask : measure

	// ----------------------------------------
	// Clock, pin, timeout and sequence
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			end_sim();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, pin} = '0;
		{awaddr, araddr, awprot, arprot, wdata} = '0;
		wstrb = 4'hF;
		bad_count = 0;
		n_checks = 0;
		rs = 32'h80fc;
		fork
			forever begin
				repeat (4) @(posedge aclk);
				pin <= ~pin;
			end
		join_none
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ST, v);
		`CHK(v, SP);
		rd(CK, v);
		`CHK(v, 8'h00);
		rd(CN, v);
		`CHK(v, 8'h00);
		rd(MD, v);
		`CHK(v, 8'h00);
		rd(8'h10, v, DEC);
		`CHK(v, 8'h00);
		wr(8'h14, 8'hFF, DEC);
		wr(CK, 8'hFF);
		rd(CK, v);
		`CHK(v, 8'h3F);
		wr(ST, SP | TR | 8'h0F);
		rd(ST, v);
		`CHK(v, SP);
		for (int p = 0; p < 16; p++) begin
			rs = lfsr(rs);
			measure(2'h0, p[3:0], (p < 8) ? ((6 + int'(rs[4:0])) << p) : (6 << 8));
		end
		for (int s = 1; s < 4; s++) begin
			rs = lfsr(rs);
			measure(s[1:0], {3'h0, s[1]}, (8 << s[1]) * (6 + int'(rs[4:0])));
		end
		rs = lfsr(rs);
		m = 8'h02 + {4'h0, rs[3:0]};
		wr(CK, 8'h00);
		wr(MD, m);
		rd(MD, v);
		`CHK(v, m);
		rd(CN, v);
		`CHK(v, 8'h00);
		wr(ST, 8'h00);
		repeat (3 * (m + 4)) @(posedge aclk);
		`CHK(overflow_irq, 1'b0);
		wr(ST, SP);
		rd(ST, v);
		`CHK(v, F | SP);
		rd(CN, v);
		`CHK(v <= m, 1'b1);
		wr(ST, SP);
		rd(ST, v);
		`CHK(v, SP);
		wr(ST, 8'h00);
		repeat (3 * (m + 4)) @(posedge aclk);
		rd(ST, v);
		`CHK(v, F);
		repeat (3 * (m + 4)) @(posedge aclk);
		wr(ST, SP);
		rd(ST, v);
		`CHK(v, F | SP);
		wr(ST, SP);
		// The flag is clear before the enable goes up.
		wr(ST, IE);
		for (k = 0; k < 200 && overflow_irq !== 1'b1; k++) @(posedge aclk);
		`CHK(overflow_irq, 1'b1);
		wr(ST, IE | SP);
		rd(ST, v);
		`CHK(v, F | IE | SP);
		wr(ST, SP);
		repeat (2) @(posedge aclk);
		`CHK(overflow_irq, 1'b0);
		wr(ST, 8'h00);
		repeat (3 * (m + 4)) @(posedge aclk);
		wr(ST, SP | TR);
		rd(ST, v);
		`CHK(v, SP);
		rd(CN, v);
		`CHK(v, 8'h00);
		wr(ST, 8'h00);
		repeat (3 * (m + 4)) @(posedge aclk);
		wr(ST, SP);
		wr(MD, 8'h00);
		rd(ST, v);
		`CHK(v, SP);
		rd(CN, v);
		`CHK(v, 8'h00);
		wr(ST, 8'h00);
		repeat (200) @(posedge aclk);
		wr(ST, SP);
		rd(ST, v);
		`CHK(v, SP);
		rd(CN, v);
		`CHK(in_tol(v, 203), 1'b1);
		wr(ST, 8'h00);
		repeat (100) @(posedge aclk);
		wr(ST, SP);
		rd(ST, v);
		`CHK(v, F | SP);
		end_sim();
	end
endmodule : modulo_timer_bench
`undef CHK
`default_nettype wire
